// [hw/rcc_pkg.sv]
package rcc_pkg;
    // =========================================================
    // Timing
    localparam int CLK_NS   = 10;
    localparam int HOLD_NS  = 500;
    localparam int HOLD_CYC = (HOLD_NS + CLK_NS - 1) / CLK_NS;
    localparam logic [7:0] HOLD_CNT = 8'(HOLD_CYC);
    localparam int BCLK_DIV = 2;
    localparam logic [3:0] BCLK_LAST = 4'(BCLK_DIV - 1);
    localparam logic [7:0] REF_WIN = 8'h10;
    // =========================================================
    // Register map
    localparam int ADDR_W = 12;
    localparam logic [11:0] OFS_CTRL   = 12'h000;
    localparam logic [11:0] OFS_CAUSE  = 12'h004;
    localparam logic [11:0] OFS_STATUS = 12'h008;
    localparam logic [11:0] OFS_CFG    = 12'h00c;
    localparam int CTRL_HARD = 0;
    localparam int CTRL_SOFT = 1;
    localparam int CAUSE_POR  = 0;
    localparam int CAUSE_HARD = 1;
    localparam int CAUSE_SOFT = 2;
    localparam int ST_REF  = 2;
    localparam int ST_POR  = 3;
    localparam int ST_HPIN = 4;
    localparam int ST_SPIN = 5;
    localparam logic [1:0] RESP_OKAY   = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
    // =========================================================
    // Types
    typedef enum logic [1:0] {
        S_POR  = 2'h0,
        S_HARD = 2'h1,
        S_RUN  = 2'h3,
        S_SOFT = 2'h2
    } rcc_state_e;
    typedef struct packed {
        logic [2:0] boot_mode_sel;
        logic [1:0] clock_mode_sel;
        logic       watchdog_enable_strap;
        logic       host_port_sync_strap;
        logic       host_port_wide_strap;
        logic       config_source_strap;
        logic [3:0] device_index_strap;
    } rcc_strap_s;
    typedef struct packed {
        logic       reset_config_strobe;
        rcc_strap_s strap;
    } rcc_cfg_s;
    localparam rcc_cfg_s CFG_RST = '0;
    localparam int SYNC_W = $bits(rcc_strap_s) + 5;
endpackage : rcc_pkg

// [hw/rcc_top.sv]
// The AXI4-Lite slave port and the address map were left to the implementer.
`timescale 1ns/100ps
module rcc_top (
    // Clock and reset
    input  wire logic                     aclk,
    input  wire logic                     aresetn,
    // Reset, strap and clock pins
    input  wire logic                     power_on_reset_in_n,
    input  wire logic                     reset_config_strobe_n,
    input  wire rcc_pkg::rcc_strap_s      strap_in,
    input  wire logic                     ref_clock_in,
    input  wire logic                     hard_reset_io_n_i,
    output logic                          hard_reset_io_n_o,
    output logic                          hard_reset_io_oe,
    input  wire logic                     soft_reset_io_n_i,
    output logic                          soft_reset_io_n_o,
    output logic                          soft_reset_io_oe,
    output logic                          bus_clock_out,
    // Internal reset and configuration outputs
    output logic                          hard_domain_rst_n,
    output logic                          soft_domain_rst_n,
    output rcc_pkg::rcc_cfg_s             cfg_out,
    // AXI4-Lite slave
    input  wire logic [rcc_pkg::ADDR_W-1:0] s_axi_awaddr,
    input  wire logic                     s_axi_awvalid,
    output logic                          s_axi_awready,
    input  wire logic [31:0]              s_axi_wdata,
    input  wire logic [3:0]               s_axi_wstrb,
    input  wire logic                     s_axi_wvalid,
    output logic                          s_axi_wready,
    output logic [1:0]                    s_axi_bresp,
    output logic                          s_axi_bvalid,
    input  wire logic                     s_axi_bready,
    input  wire logic [rcc_pkg::ADDR_W-1:0] s_axi_araddr,
    input  wire logic                     s_axi_arvalid,
    output logic                          s_axi_arready,
    output logic [31:0]                   s_axi_rdata,
    output logic [1:0]                    s_axi_rresp,
    output logic                          s_axi_rvalid,
    input  wire logic                     s_axi_rready
);
    import rcc_pkg::*;

    // =========================================================
    // Pin synchronisers
    logic [SYNC_W-1:0] sync1_r;
    logic [SYNC_W-1:0] sync2_r;
    logic              por_s;
    logic              conf_s;
    logic              hard_s;
    logic              soft_s;
    logic              ref_s;
    rcc_strap_s        strap_s;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            sync1_r <= '0;
            sync2_r <= '0;
        end else begin
            // Ref clock is slow enough here to be sampled, not clocked on
            sync1_r <= {ref_clock_in, soft_reset_io_n_i, hard_reset_io_n_i,
                        reset_config_strobe_n, power_on_reset_in_n, strap_in};
            sync2_r <= sync1_r;
        end
    end
    assign {ref_s, soft_s, hard_s, conf_s, por_s, strap_s} = sync2_r;

    // =========================================================
    // Strap capture
    logic     por_d_r;
    logic     por_rise;
    rcc_cfg_s cfg_r;
    rcc_cfg_s cfg_nxt;

    assign por_rise = por_s & ~por_d_r;
    always_comb begin
        cfg_nxt = cfg_r;
        // Only the release edge loads; hard and soft resets leave it alone
        if (por_rise) begin
            cfg_nxt.reset_config_strobe = ~conf_s;
            cfg_nxt.strap               = strap_s;
        end
    end
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            por_d_r <= 1'b0;
            cfg_r   <= CFG_RST;
        end else begin
            por_d_r <= por_s;
            cfg_r   <= cfg_nxt;
        end
    end
    assign cfg_out = cfg_r;

    // =========================================================
    // Reset state machine
    rcc_state_e state_r;
    rcc_state_e state_nxt;
    logic [7:0] cnt_r;
    logic [7:0] cnt_nxt;
    logic       hard_oe_nxt;
    logic       soft_oe_nxt;
    logic       sw_hard;
    logic       sw_soft;
    logic       hold_done;
    logic [2:0] cause_set;

    assign hold_done = (cnt_r == HOLD_CNT);
    always_comb begin
        state_nxt = state_r;
        cnt_nxt   = hold_done ? cnt_r : cnt_r + 8'h01;
        cause_set = 3'h0;
        if (!por_s) begin
            state_nxt = S_POR;
            cnt_nxt   = 8'h00;
        end else begin
            case (state_r)
                S_POR: begin
                    state_nxt = S_HARD;
                    cnt_nxt   = 8'h00;
                    cause_set[CAUSE_POR] = 1'b1;
                end
                S_HARD: begin
                    // Wait for the board to let the pin rise after our release
                    if (hold_done && hard_s) begin
                        state_nxt = S_RUN;
                    end
                end
                S_RUN, S_SOFT: begin
                    if (!hard_s || sw_hard) begin
                        state_nxt = S_HARD;
                        cnt_nxt   = 8'h00;
                        cause_set[CAUSE_HARD] = 1'b1;
                    end else if (state_r == S_RUN && (!soft_s || sw_soft)) begin
                        state_nxt = S_SOFT;
                        cnt_nxt   = 8'h00;
                        cause_set[CAUSE_SOFT] = 1'b1;
                    end else if (state_r == S_SOFT && hold_done && soft_s) begin
                        state_nxt = S_RUN;
                    end
                end
                default: state_nxt = S_POR;
            endcase
        end
        // Open-drain: enable only, level always low
        hard_oe_nxt = (state_nxt == S_POR) ||
                      (state_nxt == S_HARD && cnt_nxt != HOLD_CNT);
        soft_oe_nxt = (state_nxt == S_POR) ||
                      (state_nxt == S_SOFT && cnt_nxt != HOLD_CNT);
    end
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            state_r           <= S_POR;
            cnt_r             <= 8'h00;
            hard_reset_io_oe  <= 1'b1;
            soft_reset_io_oe  <= 1'b1;
            hard_reset_io_n_o <= 1'b0;
            soft_reset_io_n_o <= 1'b0;
            hard_domain_rst_n <= 1'b0;
            soft_domain_rst_n <= 1'b0;
        end else begin
            state_r           <= state_nxt;
            cnt_r             <= cnt_nxt;
            hard_reset_io_oe  <= hard_oe_nxt;
            soft_reset_io_oe  <= soft_oe_nxt;
            hard_reset_io_n_o <= 1'b0;
            soft_reset_io_n_o <= 1'b0;
            hard_domain_rst_n <= (state_nxt == S_RUN) || (state_nxt == S_SOFT);
            soft_domain_rst_n <= (state_nxt == S_RUN);
        end
    end

    // =========================================================
    // Bus clock and reference clock monitor
    logic [3:0] div_r;
    logic       bclk_en;
    logic       ref_d_r;
    logic [7:0] ref_cnt_r;
    logic [7:0] ref_cnt_nxt;

    assign bclk_en = (div_r == BCLK_LAST);
    always_comb begin
        ref_cnt_nxt = ref_cnt_r;
        if (ref_s != ref_d_r) begin
            ref_cnt_nxt = REF_WIN;
        end else if (ref_cnt_r != 8'h00) begin
            ref_cnt_nxt = ref_cnt_r - 8'h01;
        end
    end
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            div_r         <= 4'h0;
            bus_clock_out <= 1'b0;
            ref_d_r       <= 1'b0;
            ref_cnt_r     <= 8'h00;
        end else begin
            div_r         <= bclk_en ? 4'h0 : div_r + 4'h1;
            bus_clock_out <= bus_clock_out ^ bclk_en;
            ref_d_r       <= ref_s;
            ref_cnt_r     <= ref_cnt_nxt;
        end
    end

    // =========================================================
    // AXI4-Lite register slave
    logic        aw_held_r;
    logic        w_held_r;
    logic [11:0] awaddr_r;
    logic [31:0] wdata_r;
    logic        wstrb0_r;
    logic [2:0]  cause_r;
    logic        aw_held_nxt;
    logic        w_held_nxt;
    logic [11:0] awaddr_nxt;
    logic [31:0] wdata_nxt;
    logic        wstrb0_nxt;
    logic        bvalid_nxt;
    logic [1:0]  bresp_nxt;
    logic        arready_nxt;
    logic        rvalid_nxt;
    logic [31:0] rdata_nxt;
    logic [1:0]  rresp_nxt;
    logic [2:0]  cause_clr;
    logic        do_wr;

    assign do_wr   = aw_held_r & w_held_r & ~s_axi_bvalid;
    assign sw_hard = do_wr & wstrb0_r & (awaddr_r == OFS_CTRL) & wdata_r[CTRL_HARD];
    assign sw_soft = do_wr & wstrb0_r & (awaddr_r == OFS_CTRL) & wdata_r[CTRL_SOFT];
    always_comb begin
        aw_held_nxt = aw_held_r;
        w_held_nxt  = w_held_r;
        awaddr_nxt  = awaddr_r;
        wdata_nxt   = wdata_r;
        wstrb0_nxt  = wstrb0_r;
        bvalid_nxt  = s_axi_bvalid;
        bresp_nxt   = s_axi_bresp;
        cause_clr   = 3'h0;
        if (s_axi_awvalid && s_axi_awready) begin
            aw_held_nxt = 1'b1;
            awaddr_nxt  = s_axi_awaddr;
        end
        if (s_axi_wvalid && s_axi_wready) begin
            w_held_nxt = 1'b1;
            wdata_nxt  = s_axi_wdata;
            wstrb0_nxt = s_axi_wstrb[0];
        end
        if (s_axi_bvalid && s_axi_bready) begin
            bvalid_nxt = 1'b0;
        end
        if (do_wr) begin
            aw_held_nxt = 1'b0;
            w_held_nxt  = 1'b0;
            bvalid_nxt  = 1'b1;
            bresp_nxt   = RESP_OKAY;
            if (awaddr_r == OFS_CAUSE) begin
                cause_clr = wstrb0_r ? wdata_r[2:0] : 3'h0;
            end else if (awaddr_r != OFS_CTRL && awaddr_r != OFS_STATUS &&
                         awaddr_r != OFS_CFG) begin
                bresp_nxt = RESP_SLVERR;
            end
        end
    end

    always_comb begin
        // Ready returns whenever no read answer is pending; reset loads it low, so it first rises one cycle after reset
        arready_nxt = ~s_axi_rvalid;
        rvalid_nxt  = s_axi_rvalid;
        rdata_nxt   = s_axi_rdata;
        rresp_nxt   = s_axi_rresp;
        if (s_axi_rvalid && s_axi_rready) begin
            rvalid_nxt  = 1'b0;
            arready_nxt = 1'b1;
        end
        if (s_axi_arvalid && s_axi_arready) begin
            arready_nxt = 1'b0;
            rvalid_nxt  = 1'b1;
            rresp_nxt   = RESP_OKAY;
            rdata_nxt   = 32'h0000_0000;
            if (s_axi_araddr == OFS_CTRL) begin
                rdata_nxt = 32'h0000_0000;
            end else if (s_axi_araddr == OFS_CAUSE) begin
                rdata_nxt[2:0] = cause_r;
            end else if (s_axi_araddr == OFS_STATUS) begin
                rdata_nxt[1:0]     = state_r;
                rdata_nxt[ST_REF]  = (ref_cnt_r != 8'h00);
                rdata_nxt[ST_POR]  = por_s;
                rdata_nxt[ST_HPIN] = hard_s;
                rdata_nxt[ST_SPIN] = soft_s;
            end else if (s_axi_araddr == OFS_CFG) begin
                rdata_nxt[$bits(rcc_cfg_s)-1:0] = cfg_r;
            end else begin
                rresp_nxt = RESP_SLVERR;
            end
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_held_r     <= 1'b0;
            w_held_r      <= 1'b0;
            awaddr_r      <= 12'h000;
            wdata_r       <= 32'h0000_0000;
            wstrb0_r      <= 1'b0;
            s_axi_awready <= 1'b0;
            s_axi_wready  <= 1'b0;
            s_axi_bvalid  <= 1'b0;
            s_axi_bresp   <= RESP_OKAY;
            s_axi_arready <= 1'b0;
            s_axi_rvalid  <= 1'b0;
            s_axi_rdata   <= 32'h0000_0000;
            s_axi_rresp   <= RESP_OKAY;
            cause_r       <= 3'h0;
        end else begin
            aw_held_r     <= aw_held_nxt;
            w_held_r      <= w_held_nxt;
            awaddr_r      <= awaddr_nxt;
            wdata_r       <= wdata_nxt;
            wstrb0_r      <= wstrb0_nxt;
            s_axi_awready <= ~aw_held_nxt & ~bvalid_nxt;
            s_axi_wready  <= ~w_held_nxt & ~bvalid_nxt;
            s_axi_bvalid  <= bvalid_nxt;
            s_axi_bresp   <= bresp_nxt;
            s_axi_arready <= arready_nxt & ~rvalid_nxt;
            s_axi_rvalid  <= rvalid_nxt;
            s_axi_rdata   <= rdata_nxt;
            s_axi_rresp   <= rresp_nxt;
            // Set wins over a simultaneous write-one-to-clear
            cause_r       <= (cause_r & ~cause_clr) | cause_set;
        end
    end

    // =========================================================
    // Assertions
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    sequence s_hard_in;
        por_s && state_r == S_RUN && !hard_s;
    endsequence
    sequence s_hard_drive;
        state_r == S_HARD && hard_reset_io_oe && !hard_domain_rst_n;
    endsequence
    sequence s_soft_in;
        por_s && state_r == S_RUN && hard_s && !sw_hard && !soft_s;
    endsequence
    sequence s_soft_drive;
        state_r == S_SOFT && soft_reset_io_oe && !soft_domain_rst_n;
    endsequence

    a_por_hold: assert property (!por_s |=> state_r == S_POR && hard_reset_io_oe)
        else $error("power-on reset not entered");
    a_conf_sample: assert property (por_rise |=>
        cfg_r.reset_config_strobe == !$past(conf_s))
        else $error("config strobe not sampled");
    a_boot_capture: assert property (por_rise |=>
        cfg_out.strap.boot_mode_sel == $past(strap_s.boot_mode_sel))
        else $error("boot mode not captured");
    a_clock_capture: assert property (por_rise |=>
        cfg_out.strap.clock_mode_sel == $past(strap_s.clock_mode_sel))
        else $error("clock mode not captured");
    a_wdog_capture: assert property (por_rise |=>
        cfg_out.strap.watchdog_enable_strap == $past(strap_s.watchdog_enable_strap))
        else $error("watchdog strap not captured");
    a_host_capture: assert property (por_rise |=>
        cfg_out.strap.device_index_strap == $past(strap_s.device_index_strap) &&
        cfg_out.strap.config_source_strap == $past(strap_s.config_source_strap) &&
        cfg_out.strap.host_port_sync_strap == $past(strap_s.host_port_sync_strap))
        else $error("host port straps not captured");
    a_wide_capture: assert property (por_rise |=>
        cfg_out.strap.host_port_wide_strap == $past(strap_s.host_port_wide_strap))
        else $error("bus width strap not captured");
    a_cfg_stable: assert property (!por_rise |=> $stable(cfg_out))
        else $error("captured straps changed without power-on reset");
    a_hard_entry: assert property (s_hard_in |=> s_hard_drive)
        else $error("hard reset not entered or pin not driven");
    a_hard_release: assert property (state_r == S_HARD && hold_done |->
        !hard_reset_io_oe)
        else $error("hard reset pin held past drive time");
    a_soft_entry: assert property (s_soft_in |=> s_soft_drive)
        else $error("soft reset not entered or pin not driven");
    a_bus_clock: assert property (bclk_en |=> bus_clock_out != $past(bus_clock_out)
        && !bclk_en ##1 bclk_en)
        else $error("bus clock did not toggle");
endmodule : rcc_top

// [tb/rcc_board.sv]
`timescale 1ns/100ps
module rcc_board (
    // Clock
    input  wire logic                aclk,
    // Bench commands
    input  wire logic                por_hold,
    input  wire logic                cfg_low,
    input  wire rcc_pkg::rcc_strap_s strap_set,
    input  wire logic                hard_hold,
    input  wire logic                soft_hold,
    // Device pins
    output logic                     power_on_reset_in_n,
    output logic                     reset_config_strobe_n,
    output rcc_pkg::rcc_strap_s      strap_in,
    output logic                     ref_clock_in,
    input  wire logic                hard_n_o,
    input  wire logic                hard_oe,
    input  wire logic                soft_n_o,
    input  wire logic                soft_oe,
    output logic                     hard_pin_n,
    output logic                     soft_pin_n
);
    import rcc_pkg::*;
    logic [7:0] since_rel;
    logic [1:0] ref_div;
    initial begin
        power_on_reset_in_n   = 1'b0;
        reset_config_strobe_n = 1'b1;
        strap_in              = '0;
        ref_clock_in          = 1'b0;
        since_rel             = 8'h00;
        ref_div               = 2'h0;
    end
    // ==========================================
    // Pins and straps
    always @(posedge aclk) begin
        power_on_reset_in_n <= ~por_hold;
        ref_div <= ref_div + 2'h1;
        if (ref_div == 2'h3) begin
            ref_clock_in <= ~ref_clock_in;
        end
        if (por_hold) begin
            since_rel <= 8'h00;
        end else if (since_rel != 8'hff) begin
            since_rel <= since_rel + 8'h01;
        end
        // Straps only held briefly after release, then the lines wander
        if (since_rel < 8'h08) begin
            strap_in              <= strap_set;
            reset_config_strobe_n <= ~cfg_low;
        end else begin
            strap_in              <= ~strap_in;
            reset_config_strobe_n <= ~reset_config_strobe_n;
        end
    end
    // Open drain with pull-up: low if either party pulls
    assign hard_pin_n = ~(hard_hold | (hard_oe & ~hard_n_o));
    assign soft_pin_n = ~(soft_hold | (soft_oe & ~soft_n_o));
endmodule : rcc_board

// [tb/reset_config_capture_tb_top.sv]
`timescale 1ns/100ps
module reset_config_capture_tb_top;
    import rcc_pkg::*;
    // ==========================================
    // Signals
    logic              aclk, aresetn, por_hold, cfg_low, hard_hold, soft_hold;
    rcc_strap_s        strap_set, strap_in;
    rcc_cfg_s          cfg_out;
    logic              por_n, cfg_n, ref_clk, hard_n_i, hard_n_o, hard_oe;
    logic              soft_n_i, soft_n_o, soft_oe, bclk, hard_rst_n, soft_rst_n;
    logic [ADDR_W-1:0] awaddr, araddr;
    logic [31:0]       wdata, rdata, d;
    logic [3:0]        wstrb;
    logic [1:0]        bresp, rresp, r;
    logic              awvalid, awready, wvalid, wready, bvalid, bready;
    logic              arvalid, arready, rvalid, rready, prev;
    rcc_cfg_s          cfg_a;
    int                bad_count, checks, n, k;

    initial begin
        aclk = 1'b0;
        forever #5 aclk = ~aclk;
    end

    rcc_board i_rcc_board (.aclk(aclk), .por_hold(por_hold), .cfg_low(cfg_low),
        .strap_set(strap_set), .hard_hold(hard_hold), .soft_hold(soft_hold),
        .power_on_reset_in_n(por_n), .reset_config_strobe_n(cfg_n), .strap_in(strap_in),
        .ref_clock_in(ref_clk), .hard_n_o(hard_n_o), .hard_oe(hard_oe), .soft_n_o(soft_n_o),
        .soft_oe(soft_oe), .hard_pin_n(hard_n_i), .soft_pin_n(soft_n_i));

    rcc_top i_rcc_top (.aclk(aclk), .aresetn(aresetn), .power_on_reset_in_n(por_n),
        .reset_config_strobe_n(cfg_n), .strap_in(strap_in), .ref_clock_in(ref_clk),
        .hard_reset_io_n_i(hard_n_i), .hard_reset_io_n_o(hard_n_o),
        .hard_reset_io_oe(hard_oe), .soft_reset_io_n_i(soft_n_i),
        .soft_reset_io_n_o(soft_n_o), .soft_reset_io_oe(soft_oe), .bus_clock_out(bclk),
        .hard_domain_rst_n(hard_rst_n), .soft_domain_rst_n(soft_rst_n), .cfg_out(cfg_out),
        .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
        .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
        .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
        .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
        .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
        .s_axi_rvalid(rvalid), .s_axi_rready(rready));

    // ==========================================
    // Reporting
    task wrap_up;
        $display("checks %0d mismatches %0d", checks, bad_count);
        if (bad_count == 0 && checks > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask : wrap_up

    task chk(input logic [31:0] got, input logic [31:0] exp, input string what);
        checks++;
        if (got !== exp) begin
            bad_count++;
            $display("CHECK FAILED at %0t: %s got %h expected %h", $time, what, got, exp);
        end
    endtask : chk

    task stall;
        bad_count++;
        $display("CHECK FAILED at %0t: wait ran out", $time);
        wrap_up();
    endtask : stall

    // ==========================================
    // Waits and bus cycles
    function logic probe(input int sel);
        case (sel)
            0: return hard_rst_n;
            1: return soft_rst_n;
            2: return hard_oe;
            default: return soft_oe;
        endcase
    endfunction : probe

    task wait_for(input int sel, input logic val);
        for (n = 0; n < 400; n++) begin
            if (probe(sel) === val) break;
            @(posedge aclk);
        end
        if (n == 400) stall();
    endtask : wait_for

    // Ready seen at the edge is the pre-edge value: a true handshake
    task axi_wr(input logic [11:0] a, input logic [31:0] v, output logic [1:0] resp);
        logic aw_open, w_open;
        aw_open = 1'b1;
        w_open  = 1'b1;
        awaddr  <= a;
        wdata   <= v;
        awvalid <= 1'b1;
        wvalid  <= 1'b1;
        for (n = 0; n < 100; n++) begin
            @(posedge aclk);
            if (aw_open && awready === 1'b1) begin
                aw_open = 1'b0;
                awvalid <= 1'b0;
            end
            if (w_open && wready === 1'b1) begin
                w_open = 1'b0;
                wvalid <= 1'b0;
            end
            if (!aw_open && !w_open && bvalid === 1'b1) break;
        end
        if (n == 100) stall();
        resp = bresp;
    endtask : axi_wr

    task axi_rd(input logic [11:0] a, output logic [31:0] v, output logic [1:0] resp);
        logic open;
        open = 1'b1;
        araddr  <= a;
        arvalid <= 1'b1;
        for (n = 0; n < 100; n++) begin
            @(posedge aclk);
            if (open && arready === 1'b1) begin
                open = 1'b0;
                arvalid <= 1'b0;
            end else if (!open && rvalid === 1'b1) begin
                break;
            end
        end
        if (n == 100) stall();
        v    = rdata;
        resp = rresp;
    endtask : axi_rd

    task rd_chk(input logic [11:0] a, input logic [31:0] mask, input logic [31:0] exp);
        axi_rd(a, d, r);
        chk(d & mask, exp, "register read");
    endtask : rd_chk

    // ==========================================
    // Tests
    initial begin
        aresetn = 1'b0;  por_hold = 1'b1;  cfg_low = 1'b1;  hard_hold = 1'b0;
        soft_hold = 1'b0;  strap_set = 13'h1a5b;  awaddr = '0;  araddr = '0;
        wdata = 32'h0;  wstrb = 4'hf;  awvalid = 1'b0;  wvalid = 1'b0;
        arvalid = 1'b0;  bready = 1'b1;  rready = 1'b1;  bad_count = 0;  checks = 0;
        cfg_a = {1'b1, 13'h1a5b};
        repeat (16) @(posedge aclk);
        aresetn <= 1'b1;
        repeat (10) @(posedge aclk);
        chk({hard_rst_n, soft_rst_n, hard_oe, soft_oe}, 32'h3, "held in power-on");
        por_hold <= 1'b0;
        wait_for(0, 1'b1);
        wait_for(1, 1'b1);
        chk(cfg_out, cfg_a, "captured config");
        rd_chk(OFS_CFG, 32'hffffffff, 32'(cfg_a));
        rd_chk(OFS_STATUS, 32'h3f, 32'h3f);
        rd_chk(OFS_CAUSE, 32'h1, 32'h1);
        axi_wr(OFS_CAUSE, 32'h7, r);
        rd_chk(OFS_CAUSE, 32'h7, 32'h0);
        $display("test power_on done");
        k = 0;
        prev = bclk;
        repeat (40) begin
            @(posedge aclk);
            if (bclk !== prev) k++;
            prev = bclk;
        end
        chk(k, 40 / BCLK_DIV, "bus clock toggles");
        $display("test bus_clock done");
        // Soft pin first, then hard pin; straps wander meanwhile
        for (k = 0; k < 2; k++) begin
            if (k == 1) hard_hold <= 1'b1;
            else soft_hold <= 1'b1;
            wait_for(1 - k, 1'b0);
            wait_for(3 - k, 1'b1);
            hard_hold <= 1'b0;
            soft_hold <= 1'b0;
            repeat (10) @(posedge aclk);
            chk({hard_rst_n, soft_rst_n, probe(3 - k)}, k ? 32'h1 : 32'h5, "pin reset");
            wait_for(0, 1'b1);
            wait_for(1, 1'b1);
            chk(cfg_out, cfg_a, "config kept");
            rd_chk(OFS_CAUSE, 32'h6, k ? 32'h6 : 32'h4);
        end
        axi_wr(OFS_CTRL, 32'h2, r);
        wait_for(1, 1'b0);
        chk(hard_rst_n, 1'b1, "soft request spares hard domain");
        wait_for(1, 1'b1);
        axi_wr(OFS_CTRL, 32'h1, r);
        wait_for(0, 1'b0);
        chk({soft_rst_n, hard_oe}, 32'h1, "hard request drives pin");
        wait_for(0, 1'b1);
        wait_for(1, 1'b1);
        rd_chk(OFS_CAUSE, 32'h2, 32'h2);
        $display("test pin_resets done");
        axi_rd(12'h010, d, r);
        chk({r, d[29:0]}, {RESP_SLVERR, 30'h0}, "unmapped read");
        axi_wr(12'h010, 32'h1, r);
        chk(r, RESP_SLVERR, "unmapped write");
        axi_wr(OFS_CFG, 32'h0, r);
        chk(r, RESP_OKAY, "read-only write");
        rd_chk(OFS_CFG, 32'hffffffff, 32'(cfg_a));
        $display("test registers done");
        por_hold <= 1'b1;
        wait_for(0, 1'b0);
        wait_for(1, 1'b0);
        chk(cfg_out, cfg_a, "config kept in power-on");
        strap_set <= 13'h05a4;
        cfg_low <= 1'b0;
        repeat (10) @(posedge aclk);
        por_hold <= 1'b0;
        wait_for(0, 1'b1);
        chk(cfg_out, {1'b0, 13'h05a4}, "recaptured config");
        $display("test second_power_on done");
        wrap_up();
    end
endmodule : reset_config_capture_tb_top
